// >>> logic/pmc_pkg.sv
// package of constants and types for the power mode controller
package pmc_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] PWR_CTRL_IDX = 8'h87;
  localparam logic [11:0] PWR_CTRL_ADDR = 12'h21C;
  localparam logic [11:0] WARM_CFG_ADDR = 12'h220;
  localparam logic [11:0] STATUS_ADDR = 12'h224;
  localparam int IDLE_BIT = 0;
  localparam int STOP_BIT = 1;
  localparam int SLEEP_BIT = 2;
  localparam int TEST_BIT = 5;
  localparam int BAUD_BIT = 7;
  localparam logic [7:0] PWR_CTRL_RST = 8'h08;
  localparam logic [7:0] PWR_CTRL_FIXED = 8'h08;
  localparam logic [1:0] WARM_SEL_RST = 2'h0;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // ------------------------------------------------------------
  // warm-up counts in oscillator clocks
  // ------------------------------------------------------------
  localparam logic [11:0] WARM_CNT0 = 12'h800;
  localparam logic [11:0] WARM_CNT1 = 12'h400;
  localparam logic [11:0] WARM_CNT2 = 12'h100;
  localparam logic [11:0] WARM_CNT3 = 12'h008;
  // wake sources: ext0, ext1, keyboard, comparator, touch, watchdog
  localparam int NUM_WAKE = 6;
  localparam logic [5:0] SLEEP_WAKE_MASK = 6'h37;
  typedef enum logic [4:0] {
    PMC_RUN = 5'h01,
    PMC_IDLE = 5'h02,
    PMC_STOP = 5'h04,
    PMC_SLEEP = 5'h08,
    PMC_WARM = 5'h10
  } pmc_state_t;
endpackage

// >>> logic/pmc_ctrl.sv
// power mode controller with axi4-lite register slave
`timescale 1ns/100ps
module pmc_ctrl (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] wake_irq,
  input wire logic [5:0] wake_en,
  input wire logic irq_pending,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic eeprom_clk_en,
  output logic osc_en,
  output logic flash_pwr_en,
  output logic lvr_en,
  output logic analog_pwr_en,
  output logic port_hold,
  output logic wake_irq_take,
  output logic baud_doubler,
  output logic vector_test_mode
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [5:0] wake_meta;
  logic [5:0] wake_sync;
  logic pend_meta;
  logic pend_sync;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_meta <= 6'h00;
      wake_sync <= 6'h00;
      pend_meta <= 1'b0;
      pend_sync <= 1'b0;
    end else if (clk_en) begin
      wake_meta <= wake_irq;
      wake_sync <= wake_meta;
      pend_meta <= irq_pending;
      pend_sync <= pend_meta;
    end
  end

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic ctrl_wr;
  logic warm_wr;
  logic [7:0] pwr_ctrl;
  logic [1:0] warm_sel;
  pmc_pkg::pmc_state_t state;
  pmc_pkg::pmc_state_t next_state;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign ctrl_wr = wr_fire && aw_addr == pmc_pkg::PWR_CTRL_ADDR && w_strb[0];
  assign warm_wr = wr_fire && aw_addr == pmc_pkg::WARM_CFG_ADDR && w_strb[0];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pmc_pkg::AXI_OKAY;
    end else if (clk_en) begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == pmc_pkg::PWR_CTRL_ADDR ||
                        aw_addr == pmc_pkg::WARM_CFG_ADDR ||
                        aw_addr == pmc_pkg::STATUS_ADDR) ?
                       pmc_pkg::AXI_OKAY : pmc_pkg::AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pmc_pkg::AXI_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= pmc_pkg::AXI_OKAY;
        case (s_axi_araddr)
          // mode bits read as zero
          pmc_pkg::PWR_CTRL_ADDR: s_axi_rdata <= {24'h000000,
                                                  pwr_ctrl[7:3] | pmc_pkg::PWR_CTRL_FIXED[7:3],
                                                  3'h0};
          pmc_pkg::WARM_CFG_ADDR: s_axi_rdata <= {30'h00000000, warm_sel};
          pmc_pkg::STATUS_ADDR: s_axi_rdata <= {27'h0000000, state};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= pmc_pkg::AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // power control register
  // ------------------------------------------------------------
  logic [5:0] wake_hit;
  logic wake_any;
  logic warm_done;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ctrl <= pmc_pkg::PWR_CTRL_RST;
      warm_sel <= pmc_pkg::WARM_SEL_RST;
    end else if (clk_en) begin
      if (warm_wr) begin
        warm_sel <= w_data[1:0];
      end
      if (ctrl_wr) begin
        pwr_ctrl[pmc_pkg::BAUD_BIT] <= w_data[pmc_pkg::BAUD_BIT];
        pwr_ctrl[pmc_pkg::TEST_BIT] <= w_data[pmc_pkg::TEST_BIT];
        pwr_ctrl[pmc_pkg::IDLE_BIT] <= w_data[pmc_pkg::IDLE_BIT];
        pwr_ctrl[pmc_pkg::SLEEP_BIT] <= w_data[pmc_pkg::SLEEP_BIT];
        // sleep auto-sets stop
        pwr_ctrl[pmc_pkg::STOP_BIT] <= w_data[pmc_pkg::STOP_BIT] |
                                       w_data[pmc_pkg::SLEEP_BIT];
      end else if (state != pmc_pkg::PMC_RUN && next_state == pmc_pkg::PMC_RUN) begin
        // mode bits cleared on any wake without a control write in the same cycle
        pwr_ctrl[2:0] <= 3'h0;
      end
    end
  end

  // ------------------------------------------------------------
  // mode sequencer
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < pmc_pkg::NUM_WAKE; gi++) begin : g_wake
      assign wake_hit[gi] = wake_sync[gi] && wake_en[gi];
    end
  endgenerate
  assign wake_any = (state == pmc_pkg::PMC_SLEEP) ?
                    |(wake_hit & pmc_pkg::SLEEP_WAKE_MASK) : |wake_hit;

  logic [11:0] warm_cnt;
  logic [11:0] warm_len;
  always_comb begin
    case (warm_sel)
      2'h0: warm_len = pmc_pkg::WARM_CNT0;
      2'h1: warm_len = pmc_pkg::WARM_CNT1;
      2'h2: warm_len = pmc_pkg::WARM_CNT2;
      default: warm_len = pmc_pkg::WARM_CNT3;
    endcase
  end
  assign warm_done = warm_cnt == 12'h001;

  always_comb begin
    next_state = state;
    case (state)
      pmc_pkg::PMC_RUN: begin
        if (ctrl_wr && w_data[pmc_pkg::SLEEP_BIT]) begin
          next_state = pmc_pkg::PMC_SLEEP;
        end else if (ctrl_wr && w_data[pmc_pkg::STOP_BIT]) begin
          next_state = pmc_pkg::PMC_STOP;
        end else if (ctrl_wr && w_data[pmc_pkg::IDLE_BIT]) begin
          next_state = pmc_pkg::PMC_IDLE;
        end
      end
      pmc_pkg::PMC_IDLE: begin
        if (pend_sync) begin
          next_state = pmc_pkg::PMC_RUN;
        end
      end
      pmc_pkg::PMC_STOP, pmc_pkg::PMC_SLEEP: begin
        if (wake_any) begin
          next_state = pmc_pkg::PMC_WARM;
        end
      end
      pmc_pkg::PMC_WARM: begin
        if (warm_done) begin
          next_state = pmc_pkg::PMC_RUN;
        end
      end
      default: next_state = pmc_pkg::PMC_RUN;
    endcase
  end

  // resets end every mode through rst_n
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= pmc_pkg::PMC_RUN;
      warm_cnt <= 12'h000;
    end else if (clk_en) begin
      state <= next_state;
      if (next_state == pmc_pkg::PMC_WARM && state != pmc_pkg::PMC_WARM) begin
        warm_cnt <= warm_len;
      end else if (warm_cnt != 12'h000) begin
        warm_cnt <= warm_cnt - 12'h001;
      end
    end
  end

  // ------------------------------------------------------------
  // clock and power outputs
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      eeprom_clk_en <= 1'b1;
      osc_en <= 1'b1;
      flash_pwr_en <= 1'b1;
      lvr_en <= 1'b1;
      analog_pwr_en <= 1'b1;
      port_hold <= 1'b0;
      wake_irq_take <= 1'b0;
      baud_doubler <= 1'b0;
      vector_test_mode <= 1'b0;
    end else if (clk_en) begin
      cpu_clk_en <= next_state == pmc_pkg::PMC_RUN;
      periph_clk_en <= next_state == pmc_pkg::PMC_RUN ||
                       next_state == pmc_pkg::PMC_IDLE;
      eeprom_clk_en <= next_state == pmc_pkg::PMC_RUN ||
                       next_state == pmc_pkg::PMC_IDLE;
      osc_en <= next_state != pmc_pkg::PMC_STOP &&
                next_state != pmc_pkg::PMC_SLEEP;
      flash_pwr_en <= next_state != pmc_pkg::PMC_STOP &&
                      next_state != pmc_pkg::PMC_SLEEP;
      lvr_en <= next_state != pmc_pkg::PMC_STOP &&
                next_state != pmc_pkg::PMC_SLEEP;
      analog_pwr_en <= next_state != pmc_pkg::PMC_SLEEP;
      port_hold <= next_state == pmc_pkg::PMC_IDLE;
      // cpu takes the pending interrupt on its first running cycle
      wake_irq_take <= state != pmc_pkg::PMC_RUN &&
                       next_state == pmc_pkg::PMC_RUN;
      baud_doubler <= pwr_ctrl[pmc_pkg::BAUD_BIT];
      vector_test_mode <= pwr_ctrl[pmc_pkg::TEST_BIT];
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_idle_gates_cpu: assert property (
    clk_en && state == pmc_pkg::PMC_RUN && ctrl_wr && w_data[2:0] == 3'h1
    |=> !cpu_clk_en && periph_clk_en && port_hold)
    else $error("idle entry did not gate cpu clock");
  chk_stop_priority: assert property (
    clk_en && state == pmc_pkg::PMC_RUN && ctrl_wr && w_data[1:0] == 2'h3
    && !w_data[2] |=> state == pmc_pkg::PMC_STOP && !osc_en && !lvr_en)
    else $error("stop with idle did not enter stop");
  chk_sleep_sets_stop: assert property (
    clk_en && ctrl_wr && w_data[pmc_pkg::SLEEP_BIT]
    |=> pwr_ctrl[pmc_pkg::STOP_BIT])
    else $error("sleep did not set stop bit");
  chk_sleep_analog_off: assert property (
    state == pmc_pkg::PMC_SLEEP && $stable(state) |-> !analog_pwr_en && !flash_pwr_en)
    else $error("analog power on in sleep");
  chk_lvr_idle: assert property (
    state == pmc_pkg::PMC_IDLE |-> lvr_en && osc_en)
    else $error("lvr off during idle");
  chk_idle_exit: assert property (
    clk_en && state == pmc_pkg::PMC_IDLE && pend_sync ##1 clk_en
    |-> cpu_clk_en && wake_irq_take ##1 !wake_irq_take)
    else $error("idle exit not one cycle wake pulse");
  // first warm cycle plus seven more enabled cycles, then running
  chk_warm_len: assert property (
    $rose(state == pmc_pkg::PMC_WARM) && warm_sel == 2'h3 && clk_en ##1 clk_en [*7]
    |=> state == pmc_pkg::PMC_RUN)
    else $error("warm-up length wrong");
  chk_wake_clears: assert property (
    clk_en && state == pmc_pkg::PMC_WARM && warm_done && !ctrl_wr
    |=> pwr_ctrl[2:0] == 3'h0)
    else $error("mode bits not cleared on wake");
  chk_cpu_held_warm: assert property (
    state == pmc_pkg::PMC_WARM |-> !cpu_clk_en)
    else $error("cpu clock released during warm-up");
  chk_stop_wake: assert property (
    clk_en && state == pmc_pkg::PMC_STOP && |wake_hit |=> state == pmc_pkg::PMC_WARM)
    else $error("enabled wake source ignored in stop");
  chk_read_zero: assert property (
    s_axi_rvalid && $rose(s_axi_rvalid) && $past(s_axi_araddr) == pmc_pkg::PWR_CTRL_ADDR
    |-> s_axi_rdata[2:0] == 3'h0)
    else $error("mode bits did not read zero");

  cov_idle: cover property (state == pmc_pkg::PMC_IDLE ##[1:50] state == pmc_pkg::PMC_RUN);
  cov_stop: cover property (state == pmc_pkg::PMC_STOP ##1 state == pmc_pkg::PMC_WARM);
  cov_sleep: cover property (state == pmc_pkg::PMC_SLEEP ##1 state == pmc_pkg::PMC_WARM);
endmodule

// >>> testbench/pmc_partner.sv
// interrupt sources and pending-interrupt flag facing the power mode controller
`timescale 1ns/100ps
module pmc_partner (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic [2:0] req_src,
  input wire logic cancel,
  input wire logic wake_irq_take,
  output logic [5:0] wake_irq,
  output logic irq_pending
);
  // level request held until the core takes the wake or cancel clears it, so it spans the warm-up
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_irq <= 6'h00;
      irq_pending <= 1'b0;
    end else if (wake_irq_take || cancel) begin
      wake_irq <= 6'h00;
      irq_pending <= 1'b0;
    end else if (req) begin
      if (req_src == 3'h6) begin
        irq_pending <= 1'b1;
      end else begin
        wake_irq[req_src] <= 1'b1;
      end
    end
  end
endmodule

// >>> testbench/test_power_mode_controller.sv
// self-checking bench for the power mode controller
`timescale 1ns/100ps
module test_power_mode_controller;
  localparam logic [11:0] PC_A = pmc_pkg::PWR_CTRL_ADDR;
  localparam logic [11:0] ST_A = pmc_pkg::STATUS_ADDR;
  logic sys_clk, rst_n, clk_en, req, cancel;
  logic [2:0] req_src;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [5:0] wake_irq, wake_en;
  logic irq_pending, cpu_clk_en, periph_clk_en, eeprom_clk_en, osc_en, flash_pwr_en;
  logic lvr_en, analog_pwr_en, port_hold, wake_irq_take, baud_doubler, vector_test_mode;
  int n_fail, samples_checked, cnt;
  wire [6:0] pw = {cpu_clk_en, periph_clk_en, eeprom_clk_en, osc_en, flash_pwr_en, lvr_en,
    analog_pwr_en};

  pmc_ctrl uut (.*);
  pmc_partner partner (.*);

  // ------------------------------------------------------------
  // bus and check tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ad;
    logic dd;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    ad = 1'b0;
    dd = 1'b0;
    while (!(ad && dd)) begin
      @(posedge sys_clk);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!dd && s_axi_wready === 1'b1) begin
        dd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) begin
      @(posedge sys_clk);
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) begin
      @(posedge sys_clk);
    end
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic raise(input logic [2:0] src);
    @(posedge sys_clk);
    req <= 1'b1;
    req_src <= src;
    @(posedge sys_clk);
    req <= 1'b0;
  endtask

  // counts cycles with oscillator up and core clock still gated
  task automatic wake(input logic [2:0] src, input int lo, input int hi);
    raise(src);
    cnt = 0;
    for (int i = 0; i < 400 && cpu_clk_en !== 1'b1; i++) begin
      @(posedge sys_clk);
      if (osc_en === 1'b1 && cpu_clk_en === 1'b0) cnt++;
    end
    chk("wake_take", wake_irq_take, 1'b1);
    chk("warm_span", 32'(cnt >= lo && cnt <= hi), 1'b1);
  endtask

  task automatic no_wake(input logic [2:0] src);
    raise(src);
    repeat (40) @(posedge sys_clk);
    chk("no_wake", cpu_clk_en, 1'b0);
    cancel <= 1'b1;
    @(posedge sys_clk);
    cancel <= 1'b0;
    // let the synchronisers drain before enables change
    repeat (3) @(posedge sys_clk);
  endtask

  // ------------------------------------------------------------
  // clock, watchdog and test sequence
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (12000) @(posedge sys_clk);
    n_fail++;
    test_done();
  end

  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
    {req, cancel, req_src} = 5'h00;
    clk_en = 1'b1;
    wake_en = 6'h3F;
    n_fail = 0;
    samples_checked = 0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk("out_rst", {pw, port_hold, baud_doubler, vector_test_mode}, 10'h3F8);
    axi_rd(PC_A);
    chk("pc_rst", rdat, 32'h8);
    axi_wr(PC_A, 32'hA0, 4'h1);
    chk("wr_okay", rsp, pmc_pkg::AXI_OKAY);
    repeat (2) @(posedge sys_clk);
    chk("baud_test", {baud_doubler, vector_test_mode}, 2'h3);
    axi_wr(pmc_pkg::WARM_CFG_ADDR, 32'h3, 4'h1);
    axi_wr(PC_A, 32'hA1, 4'h0);
    axi_rd(ST_A);
    chk("strb_off", rdat, 32'h1);
    axi_wr(12'h300, 32'h1, 4'h1);
    chk("wr_unmap", rsp, pmc_pkg::AXI_SLVERR);
    axi_rd(12'h300);
    chk("rd_unmap", rdat, 32'h0);
    chk("rd_unmap_resp", rsp, pmc_pkg::AXI_SLVERR);
    axi_wr(PC_A, 32'hA1, 4'h1);
    @(posedge sys_clk);
    chk("idle_clk", pw & 7'h7A, 7'h3A);
    chk("idle_hold", port_hold, 1'b1);
    // slowed clock in idle: enable gaps must not disturb the mode
    clk_en <= 1'b0;
    repeat (3) @(posedge sys_clk);
    clk_en <= 1'b1;
    @(posedge sys_clk);
    chk("idle_slow", {port_hold, cpu_clk_en}, 2'h2);
    axi_rd(PC_A);
    chk("pc_idle", rdat, 32'hA8);
    wake(3'h6, 0, 8);
    for (int s = 0; s < 6; s++) begin
      axi_wr(PC_A, 32'hA3, 4'h1);
      @(posedge sys_clk);
      chk("stop_clk", pw & 7'h7E, 7'h00);
      axi_rd(ST_A);
      chk("stop_st", rdat, 32'h4);
      wake(3'(s), 8, 12);
      axi_rd(ST_A);
      chk("stop_clr", rdat, 32'h1);
    end
    wake_en <= 6'h3E;
    axi_wr(PC_A, 32'hA2, 4'h1);
    no_wake(3'h0);
    wake_en <= 6'h3F;
    wake(3'h1, 8, 12);
    axi_wr(PC_A, 32'hA4, 4'h1);
    @(posedge sys_clk);
    chk("sleep_pw", pw, 7'h00);
    axi_rd(ST_A);
    chk("sleep_st", rdat, 32'h8);
    no_wake(3'h3);
    wake(3'h4, 8, 12);
    axi_wr(PC_A, 32'hA4, 4'h1);
    rst_n <= 1'b0;
    repeat (2100) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk("sleep_rst", {pw, port_hold, baud_doubler}, 9'h1FC);
    axi_rd(PC_A);
    chk("pc_after", rdat, 32'h8);
    test_done();
  end
endmodule
